// [src/spsq_pkg.sv]
// constants shared by the sleep-state power sequencer
`default_nettype none
package spsq_pkg;
    // soft-start interval as a time and as oscillator cycles
    localparam int          SOFT_START_MS   = 8;
    localparam int          CLK_HZ          = 100_000_000;
    localparam longint      SS_CYCLES_FULL  = longint'(SOFT_START_MS) * CLK_HZ / 1000;
    localparam int          CNT_W           = 24;
    localparam logic [23:0] SS_CYCLES_DFLT  = SS_CYCLES_FULL[23:0];
    localparam logic [23:0] CNT_RESET       = 24'h000000;
    // decoded sleep state
    typedef enum logic [1:0] {
        PWR_S5 = 2'b00,
        PWR_S3 = 2'b01,
        PWR_S0 = 2'b10
    } spsq_pwr_t;
    // sequencer states
    typedef enum logic [2:0] {
        SQ_OFF    = 3'b000,
        SQ_WMEM   = 3'b001,
        SQ_WTERM  = 3'b010,
        SQ_RUN    = 3'b011,
        SQ_SLEEP  = 3'b100,
        SQ_LATCH  = 3'b101
    } spsq_seq_t;
endpackage
`default_nettype wire

// [src/spsq_sequencer.sv]
// sleep-state decode, rail enable sequencing and fault handling
// ****************************************************************
// What this block does
// RQ1: state from two active-low sleep inputs: second low S5, first low S3, both high S0
// RQ2: after power-up stay in S5 with standby only until sleep inputs rise
// RQ3: hold power-on reset until the high supply comparator trips, release at once
// RQ4: timer mode: after reset and one delay, start memory rail and raise main switch
// RQ5: pin mode: memory rail enabled only once its enable input is high
// RQ6: termination starts one delay after memory rail, or on its enable input rising
// RQ7: normal operation once memory and termination soft-starts have both completed
// RQ8: S0 to S3: termination off, both switches low, memory rail kept on
// RQ9: S3 to S0: after supply reset, termination starts after delay or enable rise
// RQ10: S0 to S5: standby stays on, every other regulator off
// RQ11: dual rail on in S0 and S3, off in S5; standby always on
// RQ12: memory, second buck and standby watched for undervoltage and overcurrent
// RQ13: termination watched for undervoltage only
// RQ14: thermal or standby fault turns all rails but standby off and restarts sequence
// RQ15: memory or termination fault latches S5 until second sleep input toggles
// RQ16: overcurrent on either buck places the device in S5
// RQ17: S5 drives main switch low, standby switch high; S0 both high
// RQ18: soft-start delay is a parameterised oscillator cycle count
// ****************************************************************
`default_nettype none
module spsq_sequencer #(
    parameter logic [23:0] SS_CYCLES = spsq_pkg::SS_CYCLES_DFLT  // soft-start length [RQ18]
) (
    input  wire logic clk,              // 100 MHz clock
    input  wire logic rst,              // async reset, active high
    input  wire logic sleepFirstN,      // first sleep input, active low
    input  wire logic sleepSecondN,     // second sleep input, active low
    input  wire logic highSupplyOk,     // high_supply_input above threshold
    input  wire logic pinMode,          // 1 = enable pins, 0 = internal timer
    input  wire logic memoryRailEnable, // memory_rail_enable pin
    input  wire logic terminationEnable,// termination_enable pin
    input  wire logic memSsDone,        // memory rail soft-start complete
    input  wire logic termSsDone,       // termination soft-start complete
    input  wire logic memUv,            // memory rail undervoltage
    input  wire logic memOc,            // memory rail overcurrent
    input  wire logic buck2Uv,          // second_buck undervoltage
    input  wire logic buck2Oc,          // second_buck overcurrent
    input  wire logic standbyUv,        // standby regulator undervoltage
    input  wire logic standbyOc,        // standby regulator overcurrent
    input  wire logic termUv,           // termination undervoltage
    input  wire logic thermalShdn,      // thermal shutdown
    output logic      porActive,        // power-on reset held
    output logic      memoryRailOn,     // memory rail soft-start/enable
    output logic      secondBuckOn,     // second buck enable
    output logic      terminationOn,    // termination regulator enable
    output logic      standbyOn,        // standby regulator enable
    output logic      mainRailSwitchDrive, // main_rail_switch_drive
    output logic      standbySwitchDrive,  // standby_switch_drive
    output logic      dualRailOn,       // dual rail powered
    output logic      normalOp,         // sequence complete
    output logic      faultLatched      // latched S5 fault
);
    typedef struct packed {
        spsq_pkg::spsq_seq_t seq;
        logic [23:0]         cnt;
        logic                termPrev;
        logic                sec2Prev;
        logic                latchSawLow;
        logic                mem;
        logic                b2;
        logic                term;
        logic                mainSw;
        logic                sbSw;
        logic                dual;
        logic                norm;
        logic                flt;
    } spsq_state_t;

    spsq_state_t st_r;
    spsq_state_t st_nxt;
    spsq_pkg::spsq_pwr_t pwr;
    logic                hardFault;
    logic                seqFault;
    logic                termRise;
    logic                cntDone;

    // ****************************************************************
    // decode and fault classes
    // ****************************************************************
    always_comb begin
        if (!sleepSecondN) begin
            pwr = spsq_pkg::PWR_S5;                  // [RQ1]
        end else if (!sleepFirstN) begin
            pwr = spsq_pkg::PWR_S3;                  // [RQ1]
        end else begin
            pwr = spsq_pkg::PWR_S0;                  // [RQ1]
        end
    end

    // standby and thermal faults restart; second buck undervoltage is handled alike
    assign hardFault = thermalShdn | standbyUv | standbyOc | buck2Uv;   // [RQ14] [RQ12]
    // termination has no overcurrent input at all
    assign seqFault  = memUv | memOc | termUv | buck2Oc;   // [RQ15] [RQ16] [RQ13] [RQ12]
    assign termRise  = terminationEnable & ~st_r.termPrev;
    assign cntDone   = (st_r.cnt >= SS_CYCLES);

    // ****************************************************************
    // sequencer
    // ****************************************************************
    always_comb begin
        st_nxt          = st_r;
        st_nxt.termPrev = terminationEnable;
        st_nxt.sec2Prev = sleepSecondN;
        case (st_r.seq)
            spsq_pkg::SQ_OFF: begin
                st_nxt.cnt = spsq_pkg::CNT_RESET;
                if (highSupplyOk && pwr == spsq_pkg::PWR_S0) begin   // [RQ2] [RQ3]
                    st_nxt.seq = spsq_pkg::SQ_WMEM;
                end
            end
            spsq_pkg::SQ_WMEM: begin
                st_nxt.cnt = st_r.cnt + 24'h000001;
                if (pinMode ? memoryRailEnable : cntDone) begin   // [RQ4] [RQ5]
                    st_nxt.mem    = 1'b1;
                    st_nxt.b2     = 1'b1;
                    st_nxt.mainSw = 1'b1;
                    st_nxt.sbSw   = 1'b1;
                    st_nxt.dual   = 1'b1;
                    st_nxt.cnt    = spsq_pkg::CNT_RESET;
                    st_nxt.seq    = spsq_pkg::SQ_WTERM;
                end
            end
            spsq_pkg::SQ_WTERM: begin
                st_nxt.cnt = st_r.cnt + 24'h000001;
                if (!st_r.term && (pinMode ? termRise : cntDone)) begin   // [RQ6] [RQ9]
                    st_nxt.term   = 1'b1;
                    // second buck was dropped in S3; a return to S0 must bring it back
                    st_nxt.b2     = 1'b1;
                    st_nxt.dual   = 1'b1;                // [RQ11]
                    st_nxt.mainSw = 1'b1;
                    st_nxt.sbSw   = 1'b1;
                end
                if (st_r.term && memSsDone && termSsDone) begin   // [RQ7]
                    st_nxt.norm = 1'b1;
                    st_nxt.seq  = spsq_pkg::SQ_RUN;
                end
            end
            spsq_pkg::SQ_RUN: begin
            end
            spsq_pkg::SQ_SLEEP: begin
                st_nxt.cnt = spsq_pkg::CNT_RESET;
                if (pwr == spsq_pkg::PWR_S0 && highSupplyOk) begin   // [RQ9]
                    st_nxt.seq = spsq_pkg::SQ_WTERM;
                end
            end
            spsq_pkg::SQ_LATCH: begin
                // clear only after the second sleep input has gone low and back high
                if (!sleepSecondN) begin
                    st_nxt.latchSawLow = 1'b1;
                end
                if (st_r.latchSawLow && sleepSecondN && !st_r.sec2Prev) begin   // [RQ15]
                    st_nxt.flt         = 1'b0;
                    st_nxt.latchSawLow = 1'b0;
                    st_nxt.seq         = spsq_pkg::SQ_OFF;
                end
            end
            default: begin
                st_nxt.seq = spsq_pkg::SQ_OFF;
            end
        endcase

        // S0 to S3: drop termination, both switches low, memory stays
        if (pwr == spsq_pkg::PWR_S3 && st_r.mem && st_r.seq != spsq_pkg::SQ_LATCH) begin
            st_nxt.term   = 1'b0;                    // [RQ8]
            st_nxt.b2     = 1'b0;
            st_nxt.mainSw = 1'b0;                    // [RQ8]
            st_nxt.sbSw   = 1'b0;                    // [RQ8]
            st_nxt.dual   = 1'b1;                    // [RQ11]
            st_nxt.norm   = 1'b0;
            st_nxt.seq    = spsq_pkg::SQ_SLEEP;
        end

        // S5 request, or a partial sequence losing S0, returns to standby only
        if (pwr == spsq_pkg::PWR_S5 || (pwr == spsq_pkg::PWR_S3 && !st_r.mem)) begin
            st_nxt.mem    = 1'b0;                    // [RQ10]
            st_nxt.b2     = 1'b0;                    // [RQ10]
            st_nxt.term   = 1'b0;                    // [RQ10]
            st_nxt.mainSw = 1'b0;                    // [RQ17]
            st_nxt.sbSw   = 1'b1;                    // [RQ17]
            st_nxt.dual   = 1'b0;                    // [RQ11]
            st_nxt.norm   = 1'b0;
            if (st_r.seq != spsq_pkg::SQ_LATCH) begin
                st_nxt.seq = spsq_pkg::SQ_OFF;
            end
        end

        if (seqFault && st_r.seq != spsq_pkg::SQ_LATCH && st_r.seq != spsq_pkg::SQ_OFF) begin
            st_nxt.mem         = 1'b0;               // [RQ15]
            st_nxt.b2          = 1'b0;
            st_nxt.term        = 1'b0;
            st_nxt.mainSw      = 1'b0;               // [RQ16]
            st_nxt.sbSw        = 1'b1;
            st_nxt.dual        = 1'b0;
            st_nxt.norm        = 1'b0;
            st_nxt.flt         = 1'b1;               // [RQ15]
            st_nxt.latchSawLow = ~sleepSecondN;
            st_nxt.seq         = spsq_pkg::SQ_LATCH;
        end

        // a hard fault outranks everything and re-runs from power-up
        if (hardFault || !highSupplyOk && st_r.seq == spsq_pkg::SQ_WMEM) begin
            st_nxt.mem         = 1'b0;               // [RQ14]
            st_nxt.b2          = 1'b0;
            st_nxt.term        = 1'b0;
            st_nxt.mainSw      = 1'b0;
            st_nxt.sbSw        = 1'b1;
            st_nxt.dual        = 1'b0;
            st_nxt.norm        = 1'b0;
            st_nxt.flt         = 1'b0;
            st_nxt.latchSawLow = 1'b0;
            st_nxt.cnt         = spsq_pkg::CNT_RESET;
            st_nxt.seq         = spsq_pkg::SQ_OFF;   // [RQ14]
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r          <= '0;
            st_r.seq      <= spsq_pkg::SQ_OFF;       // [RQ2]
            st_r.sbSw     <= 1'b1;
            st_r.sec2Prev <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign porActive           = ~highSupplyOk;      // [RQ3]
    assign standbyOn           = 1'b1;               // [RQ11]
    assign memoryRailOn        = st_r.mem;
    assign secondBuckOn        = st_r.b2;
    assign terminationOn       = st_r.term;
    assign mainRailSwitchDrive = st_r.mainSw;
    assign standbySwitchDrive  = st_r.sbSw;
    assign dualRailOn          = st_r.dual;
    assign normalOp            = st_r.norm;
    assign faultLatched        = st_r.flt;

    // ****************************************************************
    // checks
    // ****************************************************************
    a_s5_rails_off: assert property (@(posedge clk) disable iff (rst)
        !sleepSecondN && !hardFault |=> !memoryRailOn && !terminationOn && !dualRailOn)  // [RQ10]
        else $error("rails still on after S5 request");
    a_s5_switches: assert property (@(posedge clk) disable iff (rst)
        !sleepSecondN |=> !mainRailSwitchDrive && standbySwitchDrive)  // [RQ17]
        else $error("switch drives wrong in S5");
    a_hard_restart: assert property (@(posedge clk) disable iff (rst)
        thermalShdn |=> !memoryRailOn && !terminationOn && !faultLatched)  // [RQ14]
        else $error("thermal fault did not shut rails");
    a_mem_fault_latch: assert property (@(posedge clk) disable iff (rst)
        memOc && memoryRailOn && !hardFault |=> faultLatched && !memoryRailOn)  // [RQ15]
        else $error("memory fault did not latch S5");
    a_latch_holds: assert property (@(posedge clk) disable iff (rst)
        faultLatched && sleepSecondN && $past(sleepSecondN) && !hardFault
        |=> faultLatched)  // [RQ15]
        else $error("fault latch cleared without toggle");
    a_timer_mem_delay: assert property (@(posedge clk) disable iff (rst)
        $rose(memoryRailOn) && !pinMode && !$past(pinMode)
        |-> $past(st_r.cnt) >= SS_CYCLES)  // [RQ4]
        else $error("memory rail started before soft-start delay");
    a_pin_mem_enable: assert property (@(posedge clk) disable iff (rst)
        $rose(memoryRailOn) && $past(pinMode) |-> $past(memoryRailEnable))  // [RQ5]
        else $error("memory rail started without enable pin");
    a_s3_keeps_mem: assert property (@(posedge clk) disable iff (rst)
        memoryRailOn && sleepSecondN && !sleepFirstN && !hardFault && !seqFault
        |=> memoryRailOn && !terminationOn && dualRailOn && !mainRailSwitchDrive)  // [RQ8]
        else $error("S3 entry handled wrong");
    a_normal_done: assert property (@(posedge clk) disable iff (rst)
        $rose(normalOp) |-> $past(memSsDone) && $past(termSsDone))  // [RQ7]
        else $error("normal operation before soft-starts done");
    a_term_after_mem: assert property (@(posedge clk) disable iff (rst)
        terminationOn |-> memoryRailOn)  // [RQ6]
        else $error("termination on without memory rail");
    a_term_brings_b2: assert property (@(posedge clk) disable iff (rst)
        $rose(terminationOn) |-> secondBuckOn && mainRailSwitchDrive)  // [RQ9]
        else $error("second buck or main switch off after termination start");
    a_term_uv_latch: assert property (@(posedge clk) disable iff (rst)
        termUv && terminationOn && !hardFault |=> faultLatched && !terminationOn)  // [RQ13]
        else $error("termination undervoltage did not latch S5");
    a_buck2_oc_s5: assert property (@(posedge clk) disable iff (rst)
        buck2Oc && memoryRailOn && !hardFault |=> faultLatched && !mainRailSwitchDrive)  // [RQ16]
        else $error("second buck overcurrent did not enter S5");
endmodule
`default_nettype wire

// [verification/spsq_chipset_model.sv]
// chipset-side model: drives the sleep inputs and, in pin mode, both enable pins
`default_nettype none
module spsq_chipset_model #(
    parameter int ENA_DLY = 24  // cycles from S0 request to memory enable
) (
    input  wire logic       clk,               // 100 MHz clock
    input  wire logic       rst,               // async reset, active high
    input  wire logic [1:0] reqState,          // 0 = S5, 1 = S3, 2 = S0
    input  wire logic       pinMode,           // enables are only driven in pin mode
    input  wire logic       memoryRailOn,      // termination waits for memory rail
    output logic            sleepFirstN,       // first sleep input, active low
    output logic            sleepSecondN,      // second sleep input, active low
    output logic            memoryRailEnable,  // memory_rail_enable pin
    output logic            terminationEnable  // termination_enable pin
);
    int cnt;
    // changes land on the falling edge, away from the sequencer's sampling edge
    always @(negedge clk or posedge rst) begin
        if (rst) begin
            sleepFirstN       <= 1'b0;
            sleepSecondN      <= 1'b0;
            memoryRailEnable  <= 1'b0;
            terminationEnable <= 1'b0;
            cnt               <= 0;
        end else begin
            sleepSecondN <= (reqState != 2'h0);
            sleepFirstN  <= (reqState == 2'h2);
            if (reqState != 2'h2 || !pinMode) begin
                memoryRailEnable  <= 1'b0;
                terminationEnable <= 1'b0;
                cnt               <= 0;
            end else begin
                cnt <= cnt + 1;
                if (cnt >= ENA_DLY)
                    memoryRailEnable <= 1'b1;
                if (memoryRailOn && cnt >= 2 * ENA_DLY)
                    terminationEnable <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// [verification/spsq_sequencer_tb.sv]
// self-checking bench for the sleep-state power sequencer
`default_nettype none
module spsq_sequencer_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [23:0] SS = 24'h000008;
    localparam int          ED = 24;
    logic clk = 0, rst = 1, highSupplyOk = 0, pinMode = 0, memSsDone = 0, termSsDone = 0;
    logic [1:0] reqState = 2'h0;
    logic [7:0] flt = 8'h00;  // memUv memOc termUv buck2Oc thermal sbUv sbOc buck2Uv
    logic s1N, s2N, memEn, termEn, por, memOn, b2On, termOn, sbOn, mainSw, sbSw, dual, nrm, latched;
    int error_cnt = 0, checks_done = 0, cycles = 0, n;
    spsq_sequencer #(.SS_CYCLES(SS)) uut (.clk(clk), .rst(rst), .sleepFirstN(s1N),
        .sleepSecondN(s2N), .highSupplyOk(highSupplyOk), .pinMode(pinMode),
        .memoryRailEnable(memEn), .terminationEnable(termEn), .memSsDone(memSsDone),
        .termSsDone(termSsDone), .memUv(flt[0]), .memOc(flt[1]), .buck2Uv(flt[7]),
        .buck2Oc(flt[3]), .standbyUv(flt[5]), .standbyOc(flt[6]), .termUv(flt[2]),
        .thermalShdn(flt[4]), .porActive(por), .memoryRailOn(memOn), .secondBuckOn(b2On),
        .terminationOn(termOn), .standbyOn(sbOn), .mainRailSwitchDrive(mainSw),
        .standbySwitchDrive(sbSw), .dualRailOn(dual), .normalOp(nrm), .faultLatched(latched));
    spsq_chipset_model #(.ENA_DLY(ED)) chipset (.clk(clk), .rst(rst), .reqState(reqState),
        .pinMode(pinMode), .memoryRailOn(memOn), .sleepFirstN(s1N), .sleepSecondN(s2N),
        .memoryRailEnable(memEn), .terminationEnable(termEn));
    always #5 clk = ~clk;
    // soft-start completion follows the enables one cycle later
    always @(negedge clk) begin
        memSsDone  <= memOn;
        termSsDone <= termOn;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            error_cnt++;
            stop_test();
        end
    end
    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic check(string nm, logic [6:0] seen, logic [6:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // memory, termination, standby, main switch, standby switch, dual, latch
    function automatic logic [6:0] outs();
        return {memOn, termOn, sbOn, mainSw, sbSw, dual, latched};
    endfunction
    function automatic logic pick(int w);
        return (w == 0) ? memOn : (w == 1) ? termOn : nrm;
    endfunction
    // counts falling edges until the picked output is high, bounded by lim
    task automatic wait_hi(int w, int lim, output int cnt);
        cnt = 0;
        while (pick(w) !== 1'b1 && cnt < lim) begin
            @(negedge clk);
            cnt++;
        end
    endtask
    task automatic idle(int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic bring_up(bit timed);
        reqState = 2'h2;
        wait_hi(0, 200, n);
        if (timed) check("memDelay", 7'(n inside {[SS+1:SS+3]}), 7'h01);
        else check("memPin", 7'(n inside {[ED:ED+3]}), 7'h01);
        wait_hi(1, 200, n);
        if (timed) check("termDelay", 7'(n inside {[SS:SS+2]}), 7'h01);
        else check("termPin", 7'(n inside {[ED-3:ED+2]}), 7'h01);
        wait_hi(2, 5, n);
        check("normalOp", 7'(nrm), 7'h01);
        check("s0Outs", outs(), 7'h7E);
        check("s0Buck2", 7'(b2On), 7'h01);
    endtask
    task automatic test_end(string nm);
        $display("test %s done, mismatches so far %0d", nm, error_cnt);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ****************************************************************
    // test sequence
    // ****************************************************************
    initial begin
        repeat (20) @(negedge clk);
        rst = 0;
        check("resetOuts", outs(), 7'h14);
        reqState = 2'h2;
        idle(3 * SS);
        check("porHeld", 7'({por, memOn}), 7'h02);
        highSupplyOk = 1;
        #1;
        check("porFree", 7'(por), 7'h00);
        bring_up(1);
        test_end("timerUp");
        reqState = 2'h1;
        idle(2);
        check("s3Outs", outs(), 7'h52);
        check("s3Buck2", 7'(b2On), 7'h00);
        reqState = 2'h2;
        wait_hi(1, 200, n);
        check("s3ToS0", 7'(n inside {[SS+1:SS+4]}), 7'h01);
        wait_hi(2, 5, n);
        check("s3Normal", 7'(nrm), 7'h01);
        check("s3Back", {outs(), b2On} >> 1, 7'h7E);
        check("s3BackBuck2", 7'(b2On), 7'h01);
        reqState = 2'h0;
        idle(2);
        check("s5Outs", outs(), 7'h14);
        test_end("states");
        for (int f = 0; f < 8; f++) begin
            bring_up(1);
            flt = 8'h01 << f;
            idle(2);
            check("faultOuts", outs(), (f < 4) ? 7'h15 : 7'h14);
            flt = 8'h00;
            idle(2 * SS);
            check("afterFault", 7'(memOn), (f < 4) ? 7'h00 : 7'h01);
            if (f < 4) begin
                reqState = 2'h0;
                idle(2);
                reqState = 2'h2;
                idle(2);
                check("latchClear", 7'(latched), 7'h00);
            end
            reqState = 2'h0;
            idle(2);
        end
        test_end("faults");
        pinMode = 1;
        bring_up(0);
        test_end("pinUp");
        stop_test();
    end
endmodule
`default_nettype wire
